// ---- src/stepper_pkg.sv ----
// ----------------------------------------------------------------
// register map, field layout and reset values of the sequencer
// ----------------------------------------------------------------
package stepper_pkg;

   // word addresses on the register bus
   localparam int       ADDR_W      = 2;
   localparam logic [1:0] REG_CTRL  = 2'h0;
   localparam logic [1:0] REG_STAT  = 2'h1;
   localparam logic [1:0] REG_RATE  = 2'h2;
   localparam logic [1:0] REG_STEPS = 2'h3;

   // control register fields
   localparam int       CTRL_RUN    = 0;
   localparam int       CTRL_DIR    = 1;
   localparam logic [1:0] CTRL_RST  = 2'h0;

   // status register fields
   localparam int       STAT_WIND   = 0;
   localparam int       STAT_VAR    = 4;

   // widths of the rate divider and step counter, and reset value of the rate divider
   localparam int       RATE_WIDTH  = 16;
   localparam logic [15:0] RATE_RST = 16'h0000;
   localparam int       STEP_WIDTH  = 16;

   // single winding patterns, bit 0 is winding_a
   localparam logic [3:0] WIND_A    = 4'h1;
   localparam logic [3:0] WIND_B    = 4'h2;
   localparam logic [3:0] WIND_C    = 4'h4;
   localparam logic [3:0] WIND_D    = 4'h8;
   localparam logic [3:0] WIND_BASIC_RST = 4'h1;

   // overlap variant: only winding_b and winding_d are stored
   localparam logic     ENH_B_RST   = 1'b0;
   localparam logic     ENH_D_RST   = 1'b0;

   // build-time variant codes
   localparam bit       VAR_BASIC   = 1'b0;
   localparam bit       VAR_ENH     = 1'b1;

endpackage

// ---- src/step_tick_gen.sv ----
`timescale 1ns/100ps
// ----------------------------------------------------------------
// step rate divider: one tick every divisor+1 enabled clocks
// ----------------------------------------------------------------
module step_tick_gen
   import stepper_pkg::*;
#(
   parameter int W = RATE_WIDTH
)
(
   input  wire logic         mclk,
   input  wire logic         rst,
   input  wire logic         clk_en,
   input  wire logic         run,
   input  wire logic [W-1:0] divisor,
   output logic              tick_r
);

   logic [W-1:0] cnt_r;

   // reload while stopped so a fresh start waits a full period
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         cnt_r  <= '0;
         tick_r <= 1'b0;
      end
      else if (clk_en)
      begin
         if (!run)
         begin
            cnt_r  <= divisor;
            tick_r <= 1'b0;
         end
         else if (cnt_r == '0)
         begin
            cnt_r  <= divisor;
            tick_r <= 1'b1;
         end
         else
         begin
            cnt_r  <= cnt_r - 1'b1;
            tick_r <= 1'b0;
         end
      end
   end

endmodule

// ---- src/stepper_seq.sv ----
`timescale 1ns/100ps
module stepper_seq
   import stepper_pkg::*;
#(
   parameter bit VARIANT = VAR_BASIC,
   parameter int RATE_W  = RATE_WIDTH,
   parameter int STEP_W  = STEP_WIDTH
)
(
   input  wire logic              mclk,
   input  wire logic              rst,
   input  wire logic              clk_en,
   input  wire logic              motor_rst_n,
   input  wire logic [ADDR_W-1:0] address,
   input  wire logic              read,
   input  wire logic              write,
   input  wire logic [31:0]       writedata,
   input  wire logic [3:0]        byteenable,
   output logic [31:0]            readdata,
   output logic                   waitrequest,
   output logic                   winding_a,
   output logic                   winding_b,
   output logic                   winding_c,
   output logic                   winding_d
);

   // ----------------------------------------------------------------
   // declarations
   // ----------------------------------------------------------------
   logic              waitrequest_r;
   logic [31:0]       readdata_r;
   logic              run_r;
   logic              dir_r;
   logic [RATE_W-1:0] rate_r;
   logic [STEP_W-1:0] steps_r;
   logic              mrst_meta_r;
   logic              mrst_hold_r;
   logic              seq_rst;
   logic              tick_r;
   logic              step_go;
   logic              req;
   logic              take;
   logic              wr_ctrl;
   logic              wr_rate;
   logic              wr_steps;
   logic [3:0]        wind;
   logic [31:0]       rd_mux;

   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (rst);

   // ----------------------------------------------------------------
   // next pattern of the single-winding sequence
   // ----------------------------------------------------------------
   // an illegal pattern falls back to the start pattern instead of
   // dying out, so a disturbed register cannot leave the motor dead
   function automatic logic [3:0] next_basic
   (
      input logic [3:0] p,
      input logic       d
   );
      logic [3:0] n;
      n = WIND_BASIC_RST;
      case (p)
         WIND_A:  n = d ? WIND_D : WIND_B;
         WIND_B:  n = d ? WIND_A : WIND_C;
         WIND_C:  n = d ? WIND_B : WIND_D;
         WIND_D:  n = d ? WIND_C : WIND_A;
         default: n = WIND_BASIC_RST;
      endcase
      return n;
   endfunction

   // ----------------------------------------------------------------
   // motor reset pin
   // ----------------------------------------------------------------
   // assertion reaches the windings at once; release passes two
   // flops so the pattern never leaves reset on a metastable edge
   always_ff @(posedge mclk or posedge rst or negedge motor_rst_n)
   begin
      if (rst || !motor_rst_n)
      begin
         mrst_meta_r <= 1'b1;
         mrst_hold_r <= 1'b1;
      end
      else if (clk_en)
      begin
         mrst_meta_r <= 1'b0;
         mrst_hold_r <= mrst_meta_r;
      end
   end

   assign seq_rst = rst | ~motor_rst_n | mrst_hold_r;

   // ----------------------------------------------------------------
   // step clock
   // ----------------------------------------------------------------
   step_tick_gen #(
      .W       (RATE_W)
   ) u_tick (
      .mclk    (mclk),
      .rst     (rst),
      .clk_en  (clk_en),
      .run     (run_r),
      .divisor (rate_r),
      .tick_r  (tick_r)
   );

   // one step per tick; enable low or motor reset gives no step
   assign step_go = clk_en & tick_r & run_r & ~seq_rst;

   // ----------------------------------------------------------------
   // winding sequencer
   // ----------------------------------------------------------------
   generate
      if (VARIANT == VAR_BASIC)
      begin : g_basic
         logic [3:0] pat_r;

         // one-hot pattern, held whenever no step is due
         always_ff @(posedge mclk or posedge seq_rst)
         begin
            if (seq_rst)
               pat_r <= WIND_BASIC_RST;
            else if (step_go)
               pat_r <= next_basic(pat_r, dir_r);
         end

         assign wind = pat_r;

         one_hot_a: assert property (
            $onehot(wind))
            else $error("basic pattern is not one-hot");

         fwd_basic_a: assert property (
            (step_go && !dir_r) |=>
               (seq_rst || wind == next_basic($past(wind), 1'b0)))
            else $error("basic forward step wrong");

         rev_basic_a: assert property (
            (step_go && dir_r) |=>
               (seq_rst || wind == next_basic($past(wind), 1'b1)))
            else $error("basic reverse step wrong");

         rst_basic_a: assert property (
            seq_rst |-> (wind == WIND_A))
            else $error("basic reset pattern wrong");

         // four forward steps in a row return to the same pattern
         loop_basic_a: assert property (
            (step_go && !dir_r && !seq_rst)
               ##1 (step_go && !dir_r && !seq_rst) [*3]
               |=> (seq_rst || wind == $past(wind, 4)))
            else $error("basic sequence does not close");
      end
      else
      begin : g_enh
         logic b_r;
         logic d_r;

         // only b and d are stored; a and c follow as inverses
         always_ff @(posedge mclk or posedge seq_rst)
         begin
            if (seq_rst)
            begin
               b_r <= ENH_B_RST;
               d_r <= ENH_D_RST;
            end
            else if (step_go)
            begin
               b_r <= dir_r ? ~d_r : d_r;
               d_r <= dir_r ? b_r : ~b_r;
            end
         end

         // inverses are gates, the only outputs not from a flop
         assign wind = {d_r, ~d_r, b_r, ~b_r};

         two_on_a: assert property (
            $countones({winding_d, winding_c, winding_b, winding_a})
               == 2)
            else $error("overlap pattern lacks two windings");

         inv_pair_a: assert property (
            (winding_a == !winding_b) && (winding_c == !winding_d))
            else $error("derived windings not inverse");

         b_load_a: assert property (
            step_go |=> (seq_rst ||
               winding_b == ($past(dir_r) ? $past(winding_c)
                                          : $past(winding_d))))
            else $error("winding_b loaded wrong");

         d_load_a: assert property (
            step_go |=> (seq_rst ||
               winding_d == ($past(dir_r) ? $past(winding_b)
                                          : $past(winding_a))))
            else $error("winding_d loaded wrong");

         rst_enh_a: assert property (
            seq_rst |-> (wind == (WIND_A | WIND_C)))
            else $error("overlap reset pattern wrong");
      end
   endgenerate

   // ----------------------------------------------------------------
   // winding outputs
   // ----------------------------------------------------------------
   assign winding_a = wind[0];
   assign winding_b = wind[1];
   assign winding_c = wind[2];
   assign winding_d = wind[3];

   // ----------------------------------------------------------------
   // register bus slave
   // ----------------------------------------------------------------
   assign req  = read | write;
   // a request is taken on the edge where waitrequest is seen low
   assign take = clk_en & req & ~waitrequest_r;

   // address decode of the taken write
   always_comb
   begin
      wr_ctrl  = 1'b0;
      wr_rate  = 1'b0;
      wr_steps = 1'b0;
      if (take && write && address == REG_CTRL)
         wr_ctrl = 1'b1;
      else if (take && write && address == REG_RATE)
         wr_rate = 1'b1;
      else if (take && write && address == REG_STEPS)
         wr_steps = |byteenable;
   end

   // read mux; unmapped words read as zero
   always_comb
   begin
      rd_mux = 32'h0000_0000;
      if (address == REG_CTRL)
      begin
         rd_mux[CTRL_RUN] = run_r;
         rd_mux[CTRL_DIR] = dir_r;
      end
      else if (address == REG_STAT)
      begin
         rd_mux[STAT_WIND +: 4] = wind;
         rd_mux[STAT_VAR]       = VARIANT;
      end
      else if (address == REG_RATE)
         rd_mux[RATE_W-1:0] = rate_r;
      else if (address == REG_STEPS)
         rd_mux[STEP_W-1:0] = steps_r;
   end

   // one wait cycle per access; high while idle and in reset
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
         waitrequest_r <= 1'b1;
      else if (clk_en)
         waitrequest_r <= ~(req & waitrequest_r);
   end

   // read data loaded one edge early so it stands at the take edge
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
         readdata_r <= 32'h0000_0000;
      else if (clk_en && read && waitrequest_r)
         readdata_r <= rd_mux;
   end

   assign waitrequest = waitrequest_r;
   assign readdata    = readdata_r;

   // ----------------------------------------------------------------
   // control and rate registers
   // ----------------------------------------------------------------
   // run is the enable of the sequencer, dir its direction
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         run_r <= CTRL_RST[CTRL_RUN];
         dir_r <= CTRL_RST[CTRL_DIR];
      end
      else if (wr_ctrl && byteenable[0])
      begin
         run_r <= writedata[CTRL_RUN];
         dir_r <= writedata[CTRL_DIR];
      end
   end

   // divisor of the step clock, written per byte lane
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
         rate_r <= RATE_RST[RATE_W-1:0];
      else if (wr_rate)
      begin
         for (int i = 0; i < RATE_W / 8; i++)
            if (byteenable[i])
               rate_r[i*8 +: 8] <= writedata[i*8 +: 8];
      end
   end

   // ----------------------------------------------------------------
   // step counter
   // ----------------------------------------------------------------
   // a step in the clearing cycle still counts, so none is lost;
   // software can use it to stop after a set number of steps
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
         steps_r <= '0;
      else if (wr_steps)
         steps_r <= {{(STEP_W-1){1'b0}}, step_go};
      else if (step_go)
         steps_r <= steps_r + 1'b1;
   end

   // ----------------------------------------------------------------
   // checks common to both variants
   // ----------------------------------------------------------------
   step_moves_a: assert property (
      step_go |=> (seq_rst || wind != $past(wind)))
      else $error("step did not change the pattern");

   step_count_a: assert property (
      (step_go && !wr_steps) |=> (steps_r == $past(steps_r) + 1'b1))
      else $error("step counter missed a step");

   hold_en_a: assert property (
      (clk_en && !run_r && !seq_rst) |=> (seq_rst || $stable(wind)))
      else $error("pattern moved while disabled");

   no_tick_a: assert property (
      (!tick_r && !seq_rst) |=> (seq_rst || $stable(wind)))
      else $error("pattern moved without a step tick");

   freeze_a: assert property (
      (!clk_en && !seq_rst) |=> (seq_rst || $stable(wind)))
      else $error("pattern moved with clock enable low");

   wait_one_a: assert property (
      (clk_en && !waitrequest_r) |=> waitrequest_r)
      else $error("waitrequest low for more than one cycle");

   wait_drop_a: assert property (
      (clk_en && req && waitrequest_r) |=> !waitrequest_r)
      else $error("request not answered in one cycle");

   ctrl_wr_a: assert property (
      (wr_ctrl && byteenable[0]) |=>
         (dir_r == $past(writedata[CTRL_DIR])))
      else $error("direction write lost");

endmodule

// ---- verification/winding_driver_model.sv ----
`timescale 1ns/100ps
// ----------------------------------------------------------------
// power stage model: four winding drivers seen from the load side
// ----------------------------------------------------------------
module winding_driver_model
   import stepper_pkg::*;
#(
   parameter bit VARIANT = VAR_BASIC
)
(
   input  wire logic mclk,
   input  wire logic rst,
   input  wire logic winding_a,
   input  wire logic winding_b,
   input  wire logic winding_c,
   input  wire logic winding_d,
   output int        step_count,
   output int        bad_count
);
   logic [3:0] pat;
   logic [3:0] last;

   // the drivers simply follow the four gate levels
   assign pat = {winding_d, winding_c, winding_b, winding_a};

   initial
   begin
      step_count = 0;
      bad_count  = 0;
      last       = 4'h0;
   end

   // sampled mid-cycle so the flops have settled; a wrong phase mix
   // would short the supply through two opposed windings
   always @(negedge mclk)
   begin
      if (!rst)
      begin
         if (pat !== last)
            step_count++;
         if (VARIANT == VAR_BASIC && $countones(pat) != 1)
            bad_count++;
         if (VARIANT == VAR_ENH && (pat[0] === pat[1] ||
             pat[2] === pat[3]))
            bad_count++;
      end
      last = pat;
   end
endmodule

// ---- verification/four_phase_stepper_sequencer_tb.sv ----
`timescale 1ns/100ps
// ----------------------------------------------------------------
// bench: both variants side by side on one shared register bus
// ----------------------------------------------------------------
module four_phase_stepper_sequencer_tb
   import stepper_pkg::*;
;
   localparam int rate_div = 2;
   logic              mclk;
   logic              rst;
   logic              clk_en;
   logic              motor_rst_n;
   logic [ADDR_W-1:0] address;
   logic              read;
   logic              write;
   logic [31:0]       writedata;
   logic [3:0]        byteenable;
   logic [31:0]       readdata0;
   logic [31:0]       readdata1;
   logic [31:0]       rd0;
   logic [31:0]       rd1;
   logic              waitrequest0;
   logic              waitrequest1;
   wire  [3:0]        pb;
   wire  [3:0]        po;
   int                cnt_b;
   int                cnt_o;
   int                bad_b;
   int                bad_o;
   int                fails;
   int                total_checks;

   stepper_seq #(.VARIANT(VAR_BASIC)) stepper_seq_i (
      .mclk(mclk), .rst(rst), .clk_en(clk_en), .motor_rst_n(motor_rst_n),
      .address(address), .read(read), .write(write),
      .writedata(writedata), .byteenable(byteenable),
      .readdata(readdata0), .waitrequest(waitrequest0),
      .winding_a(pb[0]), .winding_b(pb[1]), .winding_c(pb[2]),
      .winding_d(pb[3]));
   stepper_seq #(.VARIANT(VAR_ENH)) stepper_seq_ovl_i (
      .mclk(mclk), .rst(rst), .clk_en(clk_en), .motor_rst_n(motor_rst_n),
      .address(address), .read(read), .write(write),
      .writedata(writedata), .byteenable(byteenable),
      .readdata(readdata1), .waitrequest(waitrequest1),
      .winding_a(po[0]), .winding_b(po[1]), .winding_c(po[2]),
      .winding_d(po[3]));
   winding_driver_model #(.VARIANT(VAR_BASIC)) winding_driver_model_i (
      .mclk(mclk), .rst(rst), .winding_a(pb[0]), .winding_b(pb[1]),
      .winding_c(pb[2]), .winding_d(pb[3]), .step_count(cnt_b),
      .bad_count(bad_b));
   winding_driver_model #(.VARIANT(VAR_ENH)) winding_driver_model_ovl_i (
      .mclk(mclk), .rst(rst), .winding_a(po[0]), .winding_b(po[1]),
      .winding_c(po[2]), .winding_d(po[3]), .step_count(cnt_o),
      .bad_count(bad_o));

   // 50 MHz clock
   initial
   begin
      mclk = 1'b0;
      forever #10 mclk = ~mclk;
   end

   // ----------------------------------------------------------------
   // shared tasks
   // ----------------------------------------------------------------
   task final_report;
      $display("checks %0d mismatches %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   task automatic check(input string what, input logic [31:0] seen,
                        input logic [31:0] exp);
      total_checks++;
      if (seen !== exp)
      begin
         fails++;
         $display("unexpected %s: expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic timeout(input string what);
      fails++;
      $display("unexpected %s: wait ran out", what);
      final_report();
   endtask

   // one bus access; the request stands until waitrequest is seen low
   // at a rising edge, and read data is taken at that same edge
   task automatic bus_xfer(input logic wr, input logic [1:0] adr,
                           input logic [31:0] wd);
      int n;
      n = 0;
      @(posedge mclk);
      address   <= adr;
      writedata <= wd;
      read      <= ~wr;
      write     <= wr;
      do
      begin
         @(posedge mclk);
         n++;
      end
      while (waitrequest0 !== 1'b0 && n < 50);
      if (waitrequest0 !== 1'b0)
         timeout("bus answer");
      check("overlap waitrequest", 32'(waitrequest1), 32'h0);
      rd0 = readdata0;
      rd1 = readdata1;
      read  <= 1'b0;
      write <= 1'b0;
   endtask

   // expected next pattern, bit 0 is winding_a
   function automatic logic [3:0] nxt_b(input logic [3:0] p,
                                        input logic dir);
      return dir ? {p[0], p[3:1]} : {p[2:0], p[3]};
   endfunction

   function automatic logic [3:0] nxt_o(input logic [3:0] p,
                                        input logic dir);
      logic b;
      logic d;
      b = dir ? p[2] : p[3];
      d = dir ? p[1] : p[0];
      return {d, ~d, b, ~b};
   endfunction

   // returns the cycles until the basic pattern moves
   task automatic wait_move(output int n);
      logic [3:0] s;
      n = 0;
      s = pb;
      do
      begin
         @(negedge mclk);
         n++;
      end
      while (pb === s && n < 40);
      if (n >= 40)
         timeout("step start");
   endtask

   task automatic run_steps(input int n, input logic dir);
      logic [3:0] qb;
      logic [3:0] qo;
      @(negedge mclk);
      repeat (n)
      begin
         qb = pb;
         qo = po;
         @(negedge mclk);
         check("basic step", 32'(pb), 32'(nxt_b(qb, dir)));
         check("overlap step", 32'(po), 32'(nxt_o(qo, dir)));
      end
   endtask

   task automatic hold(input int n);
      logic [3:0] qb;
      logic [3:0] qo;
      qb = pb;
      qo = po;
      repeat (n)
      begin
         @(negedge mclk);
         check("basic hold", 32'(pb), 32'(qb));
         check("overlap hold", 32'(po), 32'(qo));
      end
   endtask

   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial
   begin
      int n;
      int c0;
      fails = 0;
      total_checks = 0;
      rst = 1'b1;
      clk_en = 1'b1;
      motor_rst_n = 1'b1;
      address = '0;
      read = 1'b0;
      write = 1'b0;
      writedata = 32'h0;
      byteenable = 4'hf;
      repeat (3) @(posedge mclk);
      rst <= 1'b0;
      @(negedge mclk);
      check("basic start", 32'(pb), 32'h1);
      check("overlap start", 32'(po), 32'h5);
      bus_xfer(1'b0, REG_STAT, 32'h0);
      check("basic status", rd0, 32'h01);
      check("overlap status", rd1, 32'h15);
      $display("test reset done");

      bus_xfer(1'b1, REG_CTRL, 32'h1);
      wait_move(n);
      run_steps(8, 1'b0);
      bus_xfer(1'b1, REG_CTRL, 32'h3);
      repeat (3) @(negedge mclk);
      run_steps(8, 1'b1);
      $display("test direction done");

      // clock enable low and run low must both freeze the windings
      @(posedge mclk);
      clk_en <= 1'b0;
      @(negedge mclk);
      hold(10);
      @(posedge mclk);
      clk_en <= 1'b1;
      bus_xfer(1'b1, REG_CTRL, 32'h2);
      repeat (3) @(negedge mclk);
      hold(10);
      $display("test hold done");

      // motor reset lands between edges, not at the next one
      bus_xfer(1'b1, REG_CTRL, 32'h1);
      repeat (5) @(negedge mclk);
      @(posedge mclk);
      motor_rst_n <= 1'b0;
      #1;
      check("basic motor reset", 32'(pb), 32'h1);
      check("overlap motor reset", 32'(po), 32'h5);
      hold(3);
      @(posedge mclk);
      motor_rst_n <= 1'b1;
      wait_move(n);
      run_steps(4, 1'b0);
      $display("test motor reset done");

      bus_xfer(1'b1, REG_RATE, 32'(rate_div));
      // ticks already queued at the old rate still land; skip them
      repeat (3) wait_move(n);
      repeat (2)
      begin
         wait_move(n);
         check("step spacing", 32'(n), 32'(rate_div + 1));
      end
      bus_xfer(1'b1, REG_RATE, 32'h0);
      $display("test rate done");

      // counted run: bench drops run once five moves are seen, then checks the step counter against every move seen
      bus_xfer(1'b1, REG_CTRL, 32'h0);
      repeat (3) @(negedge mclk);
      bus_xfer(1'b1, REG_STEPS, 32'h0);
      bus_xfer(1'b0, REG_STEPS, 32'h0);
      check("steps cleared", rd0, 32'h0);
      c0 = cnt_b;
      bus_xfer(1'b1, REG_CTRL, 32'h1);
      n = 0;
      while (cnt_b - c0 < 5 && n < 100)
      begin
         @(negedge mclk);
         n++;
      end
      if (cnt_b - c0 < 5)
         timeout("counted run");
      bus_xfer(1'b1, REG_CTRL, 32'h0);
      repeat (4) @(negedge mclk);
      bus_xfer(1'b0, REG_STEPS, 32'h0);
      check("steps taken", rd0, 32'(cnt_b - c0));
      check("basic pattern faults", 32'(bad_b), 32'h0);
      check("overlap pattern faults", 32'(bad_o), 32'h0);
      $display("test step count done");
      final_report();
   end
endmodule
